// ### bso_pkg.sv
// package: offsets, fields, reset values and carriers for the error-cause and port-option bank
// ----------------------------------------------------------------
// Behaviour
// R1: address parity error on either bus that raised system error sets status bit 16.
// R2: posted write data parity error that raised system error sets bit 17.
// R3: posted write undelivered after retry limit, raising system error, sets bit 18.
// R4: target abort on posted write delivery, raising system error, sets bit 19.
// R5: master abort on posted write delivery, raising system error, sets bit 20.
// R6: delayed write undelivered after retry limit, raising system error, sets bit 21.
// R7: delayed read without any data after retry limit sets bit 22.
// R8: initiator not repeating delayed transaction before master timeout sets bit 23.
// R9: cause flags reset to zero, clear on written one, ignore written zero.
// R10: system error drives only for unmasked events with the command enable set.
// R11: option bit 1 lets primary read-line/read-multiple retries match plain read.
// R12: option bit 2 lets primary write-and-invalidate retries match plain write.
// R13: option bit 3 applies read aliasing to secondary-side read retries.
// R14: option bit 4 applies write aliasing to secondary-side write retries.
// R15: option bit 7 zero converts primary write-and-invalidate; one disconnects at lines.
// R16: option bit 8 zero converts secondary write-and-invalidate; one disconnects at lines.
// R17: option bit 9 one issues long requests for locked cycles; resets zero.
// R18: option bit 10 one holds secondary request until queue empty or termination.
// R19: option bit 11 one holds primary request until queue empty or termination.
// R20: reserved option bits 0, 5, 6 and 15:12 read zero, reset zero.
// ----------------------------------------------------------------
package bso_pkg;
	localparam logic [7:0] OFF_CAUSE = 8'h68;
	localparam logic [7:0] OFF_OPTION = 8'h74;
	localparam int CAUSE_LSB = 16;
	localparam int CAUSE_W = 8;
	localparam logic [7:0] CAUSE_RESET = 8'h00;
	localparam int OPT_W = 16;
	localparam int OPT_PRI_RD_ALIAS = 1;
	localparam int OPT_PRI_WR_ALIAS = 2;
	localparam int OPT_SEC_RD_ALIAS = 3;
	localparam int OPT_SEC_WR_ALIAS = 4;
	localparam int OPT_PRI_MWI_DISC = 7;
	localparam int OPT_SEC_MWI_DISC = 8;
	localparam int OPT_LONG_LOCK = 9;
	localparam int OPT_SEC_HOLD = 10;
	localparam int OPT_PRI_HOLD = 11;
	localparam logic [15:0] OPT_WRITABLE = 16'h0f9e;
	localparam logic [15:0] OPT_RESET = 16'h0c00;
	localparam int EV_ADDR_PAR = 0;
	localparam int EV_PW_PAR = 1;
	localparam int EV_PW_UNDELIV = 2;
	localparam int EV_PW_TABORT = 3;
	localparam int EV_PW_MABORT = 4;
	localparam int EV_DW_UNDELIV = 5;
	localparam int EV_DR_NODATA = 6;
	localparam int EV_DT_TIMEOUT = 7;
	localparam int PORT_PRI = 0;
	localparam int PORT_SEC = 1;
	localparam logic [3:0] plain_memory_read_cmd = 4'h6;
	localparam logic [3:0] plain_memory_write_cmd = 4'h7;
	localparam logic [3:0] memory_read_multiple_cmd = 4'hc;
	localparam logic [3:0] memory_read_line_cmd = 4'he;
	localparam logic [3:0] write_and_invalidate_cmd = 4'hf;

	typedef struct packed {
		logic start;
		logic frame;
		logic queue_empty;
		logic target_term;
		logic lock;
	} bso_master_in_t;

	typedef struct packed {
		logic check;
		logic side;
		logic [3:0] queued_cmd;
		logic [3:0] retry_cmd;
	} bso_retry_in_t;
endpackage

// ### bso_bank.sv
// module: error-cause flags, port options and the bridge behaviour they steer
`timescale 1ns/1ps
module bso_bank (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [7:0] cfg_addr,
	input wire logic cfg_wr,
	input wire logic cfg_rd,
	input wire logic [3:0] cfg_be,
	input wire logic [31:0] cfg_wdata,
	output logic [31:0] cfg_rdata,
	output logic cfg_rvalid,
	input wire logic [7:0] serr_event,
	input wire logic [7:0] serr_event_mask,
	input wire logic serr_enable,
	output logic primary_system_error_out_n,
	input wire bso_pkg::bso_retry_in_t retry_in,
	output logic retry_match,
	output logic retry_match_valid,
	input wire logic mwi_accept,
	input wire logic mwi_side,
	output logic [3:0] mwi_fwd_cmd,
	output logic mwi_disconnect_at_line,
	output logic mwi_fwd_valid,
	input wire bso_pkg::bso_master_in_t pri_master,
	input wire bso_pkg::bso_master_in_t sec_master,
	output logic pri_req_n,
	output logic sec_req_n,
	output logic pri_long_lock_req,
	output logic sec_long_lock_req
);
	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	logic [7:0] cause;
	logic [15:0] option;
	logic [7:0] next_cause;
	logic [15:0] next_option;
	logic [7:0] cause_set;
	logic [7:0] cause_clr;
	logic hit_cause;
	logic hit_option;

	// normalises a command under the selected aliasing
	function automatic logic [3:0] alias_cmd(input logic [3:0] cmd, input logic rd_alias,
		input logic wr_alias);
		logic [3:0] r;
		r = cmd;
		if (rd_alias && (cmd == bso_pkg::memory_read_line_cmd ||
			cmd == bso_pkg::memory_read_multiple_cmd)) begin
			r = bso_pkg::plain_memory_read_cmd;
		end
		if (wr_alias && cmd == bso_pkg::write_and_invalidate_cmd) begin
			r = bso_pkg::plain_memory_write_cmd;
		end
		return r;
	endfunction

	// next request level for one internal master
	function automatic logic req_next(input logic req_now, input bso_pkg::bso_master_in_t m,
		input logic hold);
		logic r;
		r = req_now;
		if (!req_now && m.start) begin
			r = 1'b1;
		end else if (req_now && hold && (m.queue_empty || m.target_term)) begin
			r = 1'b0;
		end else if (req_now && !hold && m.frame) begin
			r = 1'b0;
		end
		return r;
	endfunction

	assign hit_cause = (cfg_addr[7:2] == bso_pkg::OFF_CAUSE[7:2]);
	assign hit_option = (cfg_addr[7:2] == bso_pkg::OFF_OPTION[7:2]);

	// ----------------------------------------------------------------
	// cause flags
	// ----------------------------------------------------------------
	// an event is only recorded when it actually drives the error output
	always_comb begin
		cause_set = serr_event & ~serr_event_mask & {8{serr_enable}}; // R10
		cause_clr = 8'h00;
		if (cfg_wr && hit_cause && cfg_be[2]) begin
			cause_clr = cfg_wdata[bso_pkg::CAUSE_LSB +: bso_pkg::CAUSE_W]; // R9
		end
		// a set arriving with its clear wins, so no event is lost
		next_cause = (cause & ~cause_clr) | cause_set; // R9
	end

	logic flag_addr_par;
	logic flag_pw_par;
	logic flag_pw_undeliv;
	logic flag_pw_tabort;
	logic flag_pw_mabort;
	logic flag_dw_undeliv;
	logic flag_dr_nodata;
	logic flag_dt_timeout;

	// one process per flag keeps each cause separately traceable
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			flag_addr_par <= bso_pkg::CAUSE_RESET[bso_pkg::EV_ADDR_PAR]; // R9
		end else begin
			flag_addr_par <= next_cause[bso_pkg::EV_ADDR_PAR]; // R1
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			flag_pw_par <= bso_pkg::CAUSE_RESET[bso_pkg::EV_PW_PAR]; // R9
		end else begin
			flag_pw_par <= next_cause[bso_pkg::EV_PW_PAR]; // R2
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			flag_pw_undeliv <= bso_pkg::CAUSE_RESET[bso_pkg::EV_PW_UNDELIV]; // R9
		end else begin
			flag_pw_undeliv <= next_cause[bso_pkg::EV_PW_UNDELIV]; // R3
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			flag_pw_tabort <= bso_pkg::CAUSE_RESET[bso_pkg::EV_PW_TABORT]; // R9
		end else begin
			flag_pw_tabort <= next_cause[bso_pkg::EV_PW_TABORT]; // R4
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			flag_pw_mabort <= bso_pkg::CAUSE_RESET[bso_pkg::EV_PW_MABORT]; // R9
		end else begin
			flag_pw_mabort <= next_cause[bso_pkg::EV_PW_MABORT]; // R5
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			flag_dw_undeliv <= bso_pkg::CAUSE_RESET[bso_pkg::EV_DW_UNDELIV]; // R9
		end else begin
			flag_dw_undeliv <= next_cause[bso_pkg::EV_DW_UNDELIV]; // R6
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			flag_dr_nodata <= bso_pkg::CAUSE_RESET[bso_pkg::EV_DR_NODATA]; // R9
		end else begin
			flag_dr_nodata <= next_cause[bso_pkg::EV_DR_NODATA]; // R7
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			flag_dt_timeout <= bso_pkg::CAUSE_RESET[bso_pkg::EV_DT_TIMEOUT]; // R9
		end else begin
			flag_dt_timeout <= next_cause[bso_pkg::EV_DT_TIMEOUT]; // R8
		end
	end

	assign cause = {flag_dt_timeout, flag_dr_nodata, flag_dw_undeliv, flag_pw_mabort,
		flag_pw_tabort, flag_pw_undeliv, flag_pw_par, flag_addr_par};

	// output pulses low with the event, one cycle after it
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			primary_system_error_out_n <= 1'b1;
		end else begin
			primary_system_error_out_n <= ~(|cause_set); // R10
		end
	end

	// ----------------------------------------------------------------
	// port options
	// ----------------------------------------------------------------
	always_comb begin
		next_option = option;
		if (cfg_wr && hit_option) begin
			if (cfg_be[0]) begin
				next_option[7:0] = cfg_wdata[7:0];
			end
			if (cfg_be[1]) begin
				next_option[15:8] = cfg_wdata[15:8];
			end
		end
		next_option = next_option & bso_pkg::OPT_WRITABLE; // R20
	end

	logic [1:0] opt_pri_alias;
	logic [1:0] opt_sec_alias;
	logic [1:0] opt_mwi_disc;
	logic opt_long_lock;
	logic [1:0] opt_hold;

	// related option bits share a process; unowned bits are never stored at all
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			opt_pri_alias <= bso_pkg::OPT_RESET[bso_pkg::OPT_PRI_RD_ALIAS +: 2];
		end else begin
			opt_pri_alias <= next_option[bso_pkg::OPT_PRI_RD_ALIAS +: 2]; // R11 R12
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			opt_sec_alias <= bso_pkg::OPT_RESET[bso_pkg::OPT_SEC_RD_ALIAS +: 2];
		end else begin
			opt_sec_alias <= next_option[bso_pkg::OPT_SEC_RD_ALIAS +: 2]; // R13 R14
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			opt_mwi_disc <= bso_pkg::OPT_RESET[bso_pkg::OPT_PRI_MWI_DISC +: 2];
		end else begin
			opt_mwi_disc <= next_option[bso_pkg::OPT_PRI_MWI_DISC +: 2]; // R15 R16
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			opt_long_lock <= bso_pkg::OPT_RESET[bso_pkg::OPT_LONG_LOCK]; // R17
		end else begin
			opt_long_lock <= next_option[bso_pkg::OPT_LONG_LOCK]; // R17
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			opt_hold <= bso_pkg::OPT_RESET[bso_pkg::OPT_SEC_HOLD +: 2]; // R18 R19
		end else begin
			opt_hold <= next_option[bso_pkg::OPT_SEC_HOLD +: 2]; // R18 R19
		end
	end

	assign option = {4'h0, opt_hold, opt_long_lock, opt_mwi_disc, 2'h0, opt_sec_alias,
		opt_pri_alias, 1'h0}; // R20

	// ----------------------------------------------------------------
	// configuration read
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cfg_rvalid <= 1'b0;
		end else begin
			cfg_rvalid <= cfg_rd;
		end
	end

	// unmapped offsets and unowned bits of a shared dword read as zero
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cfg_rdata <= 32'h0000_0000;
		end else begin
			if (cfg_rd && hit_cause) begin
				cfg_rdata <= {8'h00, cause, 16'h0000};
			end else if (cfg_rd && hit_option) begin
				cfg_rdata <= {16'h0000, option}; // R20
			end else begin
				cfg_rdata <= 32'h0000_0000;
			end
		end
	end

	// ----------------------------------------------------------------
	// retry matching
	// ----------------------------------------------------------------
	logic rd_alias;
	logic wr_alias;
	always_comb begin
		if (retry_in.side) begin
			rd_alias = option[bso_pkg::OPT_SEC_RD_ALIAS]; // R13
			wr_alias = option[bso_pkg::OPT_SEC_WR_ALIAS]; // R14
		end else begin
			rd_alias = option[bso_pkg::OPT_PRI_RD_ALIAS]; // R11
			wr_alias = option[bso_pkg::OPT_PRI_WR_ALIAS]; // R12
		end
	end

	// with aliasing off both sides pass unchanged, which is exact matching
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			retry_match <= 1'b0;
			retry_match_valid <= 1'b0;
		end else begin
			retry_match_valid <= retry_in.check;
			retry_match <= retry_in.check &&
				(alias_cmd(retry_in.queued_cmd, rd_alias, wr_alias) ==
				alias_cmd(retry_in.retry_cmd, rd_alias, wr_alias)); // R11 R12 R13 R14
		end
	end

	// ----------------------------------------------------------------
	// write-and-invalidate forwarding
	// ----------------------------------------------------------------
	logic mwi_disc_sel;
	assign mwi_disc_sel = mwi_side ? option[bso_pkg::OPT_SEC_MWI_DISC] :
		option[bso_pkg::OPT_PRI_MWI_DISC];

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			mwi_fwd_cmd <= bso_pkg::plain_memory_write_cmd;
			mwi_disconnect_at_line <= 1'b0;
			mwi_fwd_valid <= 1'b0;
		end else begin
			mwi_fwd_valid <= mwi_accept;
			if (mwi_accept) begin
				mwi_disconnect_at_line <= mwi_disc_sel; // R15 R16
				mwi_fwd_cmd <= mwi_disc_sel ? bso_pkg::write_and_invalidate_cmd :
					bso_pkg::plain_memory_write_cmd; // R15 R16
			end
		end
	end

	// ----------------------------------------------------------------
	// internal master requests
	// ----------------------------------------------------------------
	// releasing at frame frees the bus sooner but costs re-arbitration per burst
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pri_req_n <= 1'b1;
		end else begin
			pri_req_n <= ~req_next(~pri_req_n, pri_master, option[bso_pkg::OPT_PRI_HOLD]); // R19
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			sec_req_n <= 1'b1;
		end else begin
			sec_req_n <= ~req_next(~sec_req_n, sec_master, option[bso_pkg::OPT_SEC_HOLD]); // R18
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pri_long_lock_req <= 1'b0;
		end else begin
			pri_long_lock_req <= option[bso_pkg::OPT_LONG_LOCK] && pri_master.lock; // R17
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			sec_long_lock_req <= 1'b0;
		end else begin
			sec_long_lock_req <= option[bso_pkg::OPT_LONG_LOCK] && sec_master.lock; // R17
		end
	end
endmodule

// ### bso_checker.sv
// checker: port-level assertions for the cause flag and port option bank
`timescale 1ns/1ps
module bso_checker (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic cfg_rd,
	input wire logic cfg_rvalid,
	input wire logic [7:0] serr_event,
	input wire logic [7:0] serr_event_mask,
	input wire logic serr_enable,
	input wire logic primary_system_error_out_n,
	input wire bso_pkg::bso_retry_in_t retry_in,
	input wire logic retry_match,
	input wire logic retry_match_valid,
	input wire logic mwi_accept,
	input wire logic [3:0] mwi_fwd_cmd,
	input wire logic mwi_disconnect_at_line,
	input wire logic mwi_fwd_valid,
	input wire bso_pkg::bso_master_in_t pri_master,
	input wire logic pri_req_n
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	logic live;
	assign live = |(serr_event & ~serr_event_mask) && serr_enable;
	AST_ERR_SET: assert property (live |=> !primary_system_error_out_n)
		else $error("event missed");
	AST_ERR_OFF: assert property (!live |=> primary_system_error_out_n)
		else $error("stray error pulse");
	AST_RVALID: assert property (cfg_rd |=> cfg_rvalid)
		else $error("no read valid");
	AST_RV_PULSE: assert property (!cfg_rd |=> !cfg_rvalid)
		else $error("stray read valid");
	AST_RM_VALID: assert property (retry_in.check |=> retry_match_valid)
		else $error("no match valid");
	AST_RM_EXACT: assert property (retry_in.check &&
		retry_in.queued_cmd == retry_in.retry_cmd |=> retry_match)
		else $error("equal commands unmatched");
	AST_MWI: assert property (mwi_accept |=> mwi_fwd_valid &&
		mwi_fwd_cmd == (mwi_disconnect_at_line ? 4'hf : 4'h7))
		else $error("bad forwarded command");
	AST_REQ: assert property (pri_req_n && pri_master.start |=> !pri_req_n)
		else $error("request not raised");
	cover property (!primary_system_error_out_n);
	cover property (retry_match_valid && retry_match);
	cover property (mwi_fwd_valid && mwi_disconnect_at_line);
endmodule

// ### bso_partner.sv
// partner: one bus initiator sequence seen by an internal master
`timescale 1ns/1ps
module bso_partner (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic go,
	output bso_pkg::bso_master_in_t m
);
	logic [3:0] cnt;
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			cnt <= 4'h0;
		else if (go)
			cnt <= 4'h1;
		else if (cnt != 4'h0)
			cnt <= cnt + 4'h1;
	end
	// frame two cycles after start, queue drains three later; lock spans the run
	always_comb begin
		m.start = (cnt == 4'h1);
		m.frame = (cnt == 4'h3);
		m.queue_empty = (cnt == 4'h6);
		m.target_term = 1'b0;
		m.lock = (cnt != 4'h0);
	end
endmodule

// ### bso_bank_tb_top.sv
// testbench: drives the bank through its config port and side inputs
`timescale 1ns/1ps
module bso_bank_tb_top;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic [7:0] cfg_addr = 8'h00;
	logic cfg_wr = 1'b0;
	logic cfg_rd = 1'b0;
	logic [3:0] cfg_be = 4'h0;
	logic [31:0] cfg_wdata = 32'h0;
	logic [31:0] cfg_rdata;
	logic cfg_rvalid;
	logic [7:0] serr_event = 8'h00;
	logic [7:0] serr_event_mask = 8'h00;
	logic serr_enable = 1'b1;
	logic primary_system_error_out_n;
	bso_pkg::bso_retry_in_t retry_in = '0;
	logic retry_match;
	logic retry_match_valid;
	logic mwi_accept = 1'b0;
	logic mwi_side = 1'b0;
	logic [3:0] mwi_fwd_cmd;
	logic mwi_disconnect_at_line;
	logic mwi_fwd_valid;
	bso_pkg::bso_master_in_t pri_master;
	bso_pkg::bso_master_in_t sec_master;
	logic pri_req_n;
	logic sec_req_n;
	logic pri_long_lock_req;
	logic sec_long_lock_req;
	logic [1:0] go = 2'b00;
	int error_cnt = 0;
	int n_checks = 0;
	int cyc = 0;
	always #4 clk_sys = ~clk_sys;
	bso_bank bso_bank_i (.*);
	bso_partner pri_partner (.clk_sys(clk_sys), .rst(rst), .go(go[0]), .m(pri_master));
	bso_partner sec_partner (.clk_sys(clk_sys), .rst(rst), .go(go[1]), .m(sec_master));
	task automatic close_out();
		if (error_cnt == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic ok, input string msg);
		n_checks++;
		if (ok !== 1'b1) begin
			error_cnt++;
			$display("[ERR] %0t %s", $time, msg);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
		cfg_addr = a;
		cfg_be = be;
		cfg_wdata = d;
		cfg_wr = 1'b1;
		@(negedge clk_sys);
		cfg_wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		cfg_addr = a;
		cfg_rd = 1'b1;
		@(negedge clk_sys);
		cfg_rd = 1'b0;
		chk(cfg_rvalid === 1'b1 && cfg_rdata === e, "read data");
		// idle edge so a following read never re-raises the strobe in this step
		@(negedge clk_sys);
	endtask
	task automatic t_regs();
		rd(8'h68, 32'h0);
		rd(8'h74, 32'h00000c00);
		wr(8'h74, 4'h3, 32'hffffffff);
		rd(8'h74, 32'h00000f9e);
		rd(8'h70, 32'h0);
	endtask
	task automatic t_events();
		logic [31:0] acc;
		acc = 32'h0;
		for (int i = 0; i < 8; i++) begin
			serr_event = 8'(1 << i);
			@(negedge clk_sys);
			serr_event = 8'h00;
			chk(primary_system_error_out_n === 1'b0, "no error pulse");
			acc[16+i] = 1'b1;
			rd(8'h68, acc);
		end
		chk(primary_system_error_out_n === 1'b1, "error pulse too long");
		wr(8'h68, 4'hf, 32'h0);
		rd(8'h68, acc);
		wr(8'h68, 4'h4, 32'h00550000);
		rd(8'h68, 32'h00aa0000);
		serr_event = 8'h01;
		wr(8'h68, 4'h4, 32'h00010000);
		serr_event = 8'h00;
		rd(8'h68, 32'h00ab0000);
		wr(8'h68, 4'h4, 32'h00ff0000);
		serr_event_mask = 8'hff;
		serr_event = 8'hff;
		@(negedge clk_sys);
		serr_event_mask = 8'h00;
		serr_enable = 1'b0;
		@(negedge clk_sys);
		serr_event = 8'h00;
		chk(primary_system_error_out_n === 1'b1, "masked event raised");
		rd(8'h68, 32'h0);
		serr_enable = 1'b1;
	endtask
	task automatic rt(input logic s, input logic [15:0] o, input logic [3:0] r, input logic e);
		wr(8'h74, 4'h3, {16'h0, o});
		retry_in = '{check: 1'b1, side: s, queued_cmd: r[0] ? 4'h7 : 4'h6, retry_cmd: r};
		@(negedge clk_sys);
		retry_in.check = 1'b0;
		chk(retry_match_valid === 1'b1 && retry_match === e, "retry match");
	endtask
	task automatic t_retry();
		rt(1'b0, 16'h0000, 4'he, 1'b0);
		rt(1'b0, 16'h0002, 4'he, 1'b1);
		rt(1'b0, 16'h0002, 4'hc, 1'b1);
		rt(1'b1, 16'h0002, 4'he, 1'b0);
		rt(1'b1, 16'h0008, 4'hc, 1'b1);
		rt(1'b0, 16'h0000, 4'hf, 1'b0);
		rt(1'b0, 16'h0004, 4'hf, 1'b1);
		rt(1'b1, 16'h0004, 4'hf, 1'b0);
		rt(1'b1, 16'h0010, 4'hf, 1'b1);
	endtask
	task automatic mw(input logic s, input logic [15:0] o, input logic [3:0] c, input logic d);
		wr(8'h74, 4'h3, {16'h0, o});
		mwi_side = s;
		mwi_accept = 1'b1;
		@(negedge clk_sys);
		mwi_accept = 1'b0;
		chk(mwi_fwd_valid === 1'b1 && mwi_fwd_cmd === c && mwi_disconnect_at_line === d, "mwi");
	endtask
	task automatic t_mwi();
		mw(1'b0, 16'h0000, 4'h7, 1'b0);
		mw(1'b0, 16'h0080, 4'hf, 1'b1);
		mw(1'b1, 16'h0080, 4'h7, 1'b0);
		mw(1'b1, 16'h0100, 4'hf, 1'b1);
	endtask
	// hold and long-lock bits follow h together, so one run covers both options at one setting of h
	task automatic t_req(input int s, input logic h);
		wr(8'h74, 4'h3, {20'h0, h, h, h, 9'h0});
		go[s] = 1'b1;
		@(negedge clk_sys);
		go[s] = 1'b0;
		@(negedge clk_sys);
		chk((s ? sec_req_n : pri_req_n) === 1'b0, "no request");
		chk((s ? sec_long_lock_req : pri_long_lock_req) === h, "long lock");
		repeat (2) @(negedge clk_sys);
		chk((s ? sec_req_n : pri_req_n) === ~h, "release at frame");
		repeat (3) @(negedge clk_sys);
		chk((s ? sec_req_n : pri_req_n) === 1'b1, "release at drain");
	endtask
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 3000) begin
			error_cnt++;
			close_out();
		end
	end
	initial begin
		repeat (12) @(negedge clk_sys);
		rst = 1'b0;
		t_regs();
		t_events();
		t_retry();
		t_mwi();
		for (int s = 0; s < 2; s++) begin
			t_req(s, 1'b1);
			t_req(s, 1'b0);
		end
		close_out();
	end
endmodule
bind bso_bank bso_checker bso_checker_i (.*);
